// ### swdet_pkg.sv
package swdet_pkg;

    localparam int NPROG      = 8;
    localparam int NGND       = 14;
    localparam int NSW        = NPROG + NGND;
    localparam int FRAME_BITS = 24;
    localparam int CHAIN_BITS = 2 * FRAME_BITS;
    localparam int CNT_W      = 6;

    // command header field and payload layout
    localparam int HDR_MSB    = 23;
    localparam int HDR_LSB    = 16;
    localparam int ANA_SEL_W  = 5;
    localparam int ANA_CUR_LSB = 5;
    localparam int ANA_CUR_W  = 2;

    // status word layout
    localparam int ST_INT_BIT   = 23;
    localparam int ST_THERM_BIT = 22;

    localparam logic [7:0] CMD_POLARITY = 8'h01;
    localparam logic [7:0] CMD_WAKE_P   = 8'h02;
    localparam logic [7:0] CMD_WAKE_G   = 8'h03;
    localparam logic [7:0] CMD_METAL_P  = 8'h04;
    localparam logic [7:0] CMD_METAL_G  = 8'h05;
    localparam logic [7:0] CMD_TIMER_P  = 8'h07;
    localparam logic [7:0] CMD_TIMER_G  = 8'h08;
    localparam logic [7:0] CMD_TRI_P    = 8'h09;
    localparam logic [7:0] CMD_TRI_G    = 8'h0A;
    localparam logic [7:0] CMD_ANALOG   = 8'h0B;
    localparam logic [7:0] CMD_CALIB    = 8'h0C;
    localparam logic [7:0] CMD_RESET    = 8'h0D;

    localparam logic [NPROG-1:0]     POL_RST     = 8'hFF;
    localparam logic [NSW-1:0]       ALL_ON_RST  = 22'h3FFFFF;
    localparam logic [ANA_SEL_W-1:0] ANA_SEL_RST = 5'h00;
    localparam logic [ANA_CUR_W-1:0] ANA_CUR_RST = 2'h0;

    typedef struct packed {
        logic [NPROG-1:0]     polarity;
        logic [NSW-1:0]       wake_en;
        logic [NSW-1:0]       metal_hi;
        logic [NSW-1:0]       timer_en;
        logic [NSW-1:0]       tristate;
        logic [ANA_CUR_W-1:0] ana_cur;
        logic [ANA_SEL_W-1:0] ana_sel;
    } cfg_t;

    localparam cfg_t CFG_RST = '{
        polarity: POL_RST,
        wake_en:  ALL_ON_RST,
        metal_hi: ALL_ON_RST,
        timer_en: ALL_ON_RST,
        tristate: ALL_ON_RST,
        ana_cur:  ANA_CUR_RST,
        ana_sel:  ANA_SEL_RST
    };

    typedef enum {MODE_NORMAL, MODE_SLEEP} mode_t;

endpackage

// ### sync2.sv
`timescale 1ns/10ps
module sync2 #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= RST_VAL;
            q_o    <= RST_VAL;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule

// ### switch_detect_spi_control.sv
`timescale 1ns/10ps
// Contract
// - battery polarity above reference means closed, ground opposite
// - ground-only input above reference reads open
// - every frame shifts out status, interrupt, thermal
// - chip select fall snapshots all switch states
// - valid command needs exactly 24 or 48 clocks
// - logic supply loss in Normal keeps Normal
// - logic supply loss in Sleep waits wake event
// - no logic supply: ignore SPI, cs/int falls
// - battery power-on reset leaves in Normal mode
// - reset defaults: battery, wake, 16mA, timers, tristate
// - listed events move device into Normal mode
// - commands accepted only Normal with logic supply
// - decoder supports eight command groups
// - interrupt released on cs rise unless new change
// - header 01 loads polarity bits 7..0
// - closed programmable input always reports one
// - thermal flag active only in Normal mode
// - serial input sampled on clock falling edge
// - next status bit driven after clock rise
// - command and status move MSB first
// - command acts only at chip select rise
module switch_detect_spi_control
    import swdet_pkg::*;
(
    input  wire logic             CLOCK_I,
    input  wire logic             RST_I,
    input  wire logic             SCLK_I,
    input  wire logic             CS_N_I,
    input  wire logic             SI_I,
    output logic                  SO_O,
    output logic                  SO_OE_O,
    input  wire logic             INT_N_I,
    output logic                  INT_N_O,
    output logic                  INT_N_OE_O,
    input  wire logic             WAKE_N_I,
    output logic                  WAKE_N_O,
    output logic                  WAKE_N_OE_O,
    input  wire logic             VDD_OK_I,
    input  wire logic             THERM_I,
    input  wire logic [NPROG-1:0] PROG_CMP_I,
    input  wire logic [NGND-1:0]  GND_CMP_I,
    input  wire logic             TMR_EXPIRE_I,
    input  wire logic             SLEEP_REQ_I,
    output logic      [NSW-1:0]   STATUS_O,
    output logic                  THERM_FLAG_O,
    output logic                  MODE_NORMAL_O,
    output logic                  CAL_O,
    output cfg_t                  CFG_O
);

    ////////////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic [NSW-1:0] closed_map(input logic [NPROG-1:0] pc,
                                                  input logic [NGND-1:0]  gc,
                                                  input logic [NPROG-1:0] pol);
        closed_map = {~gc, ~(pc ^ pol)};
    endfunction

    // load the programmable or the ground-only half of a per-input vector
    function automatic logic [NSW-1:0] merge(input logic [NSW-1:0]        old,
                                             input logic [FRAME_BITS-1:0] w,
                                             input logic                  gnd);
        merge = gnd ? {w[NGND-1:0], old[NPROG-1:0]} : {old[NSW-1:NPROG], w[NPROG-1:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // link domain: serial clock; bit counter and serial output reset by chip select high

    logic                  link_rst;
    logic [CNT_W-1:0]      cnt_q;
    logic                  so_q;
    logic [FRAME_BITS-1:0] rx_q;
    logic [CNT_W-1:0]      flen_q;
    logic                  frame_tgl_q;
    logic [FRAME_BITS-1:0] snap_q;
    logic [4:0]            bit_idx;

    assign link_rst = RST_I | CS_N_I;
    assign bit_idx  = 5'(FRAME_BITS - 1) - cnt_q[4:0];

    always_ff @(posedge SCLK_I or posedge link_rst) begin
        if (link_rst) begin
            cnt_q <= '0;
            so_q  <= 1'b0;
        end else begin
            if (cnt_q != {CNT_W{1'b1}}) begin
                cnt_q <= cnt_q + 1'b1;
            end
            // status first, then received bits pass through for a chain
            if (cnt_q < CNT_W'(FRAME_BITS)) begin
                so_q <= snap_q[bit_idx];
            end else begin
                so_q <= rx_q[FRAME_BITS-1];
            end
        end
    end

    always_ff @(negedge SCLK_I or posedge RST_I) begin
        if (RST_I) begin
            rx_q        <= '0;
            flen_q      <= '0;
            frame_tgl_q <= 1'b0;
        end else begin
            rx_q   <= {rx_q[FRAME_BITS-2:0], SI_I};
            flen_q <= cnt_q;
            if (cnt_q == CNT_W'(1)) begin
                frame_tgl_q <= ~frame_tgl_q;
            end
        end
    end

    assign SO_O = so_q;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers into the system clock

    localparam int SYNC_W = 6 + NSW;

    logic [SYNC_W-1:0] sync_d;
    logic [SYNC_W-1:0] sync_q;
    logic              cs_n_s;
    logic              vdd_s;
    logic              wake_n_s;
    logic              int_n_s;
    logic              therm_s;
    logic              tgl_s;
    logic [NSW-1:0]    cmp_s;

    assign sync_d = {CS_N_I, VDD_OK_I, WAKE_N_I, INT_N_I, THERM_I, frame_tgl_q,
                     GND_CMP_I, PROG_CMP_I};
    assign {cs_n_s, vdd_s, wake_n_s, int_n_s, therm_s, tgl_s, cmp_s} = sync_q;

    sync2 #(
        .W       (SYNC_W),
        .RST_VAL ({4'hF, {(SYNC_W - 4){1'b0}}})
    ) u_sync (
        .clk_i (CLOCK_I),
        .rst_i (RST_I),
        .d_i   (sync_d),
        .q_o   (sync_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // edges and switch state

    logic           cs_n_p;
    logic           wake_n_p;
    logic           int_n_p;
    logic           cs_fall;
    logic           cs_rise;
    logic           wake_fall;
    logic           int_fall;
    logic [NSW-1:0] closed_q;
    logic           closed_vld_q;
    logic [1:0]     warm_q;
    logic [NSW-1:0] closed_d;
    logic           sw_change;
    cfg_t           cfg_q;
    mode_t          mode_q;

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            cs_n_p   <= 1'b1;
            wake_n_p <= 1'b1;
            int_n_p  <= 1'b1;
        end else begin
            cs_n_p   <= cs_n_s;
            wake_n_p <= wake_n_s;
            int_n_p  <= int_n_s;
        end
    end

    assign cs_fall   = cs_n_p & ~cs_n_s;
    assign cs_rise   = ~cs_n_p & cs_n_s;
    assign wake_fall = wake_n_p & ~wake_n_s;
    assign int_fall  = int_n_p & ~int_n_s;
    assign closed_d  = closed_map(cmp_s[NPROG-1:0], cmp_s[NSW-1:NPROG], cfg_q.polarity);

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            closed_q     <= '0;
            closed_vld_q <= 1'b0;
            warm_q       <= '0;
        end else begin
            // the synchroniser holds its reset value for two edges; comparing
            // against that would raise a false interrupt after every reset
            closed_q     <= closed_d;
            warm_q       <= {warm_q[0], 1'b1};
            closed_vld_q <= warm_q[1];
        end
    end

    // a polarity write flips the decoded state without a real contact move;
    // it is reported as a change, which costs at most one extra interrupt
    assign sw_change = closed_vld_q & |((closed_d ^ closed_q) & cfg_q.wake_en);

    ////////////////////////////////////////////////////////////////////////////
    // mode

    logic wake_evt;

    assign wake_evt = sw_change
                    | (wake_fall & (~vdd_s | int_n_s))
                    | (int_fall & wake_n_s & vdd_s)
                    | (cs_fall & vdd_s)
                    | TMR_EXPIRE_I;

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            mode_q <= MODE_NORMAL;
        end else begin
            unique case (mode_q)
                MODE_NORMAL: begin
                    // supply loss is no reason to leave Normal
                    if (SLEEP_REQ_I && !wake_evt) begin
                        mode_q <= MODE_SLEEP;
                    end
                end
                MODE_SLEEP: begin
                    if (wake_evt) begin
                        mode_q <= MODE_NORMAL;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt, thermal flag and status snapshot

    logic int_q;
    logic frame_chg_q;
    logic therm_q;

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            int_q       <= 1'b0;
            frame_chg_q <= 1'b0;
        end else begin
            // a change in the fall cycle misses the snapshot, so it must win
            if (sw_change && !cs_n_s) begin
                frame_chg_q <= 1'b1;
            end else if (cs_fall) begin
                frame_chg_q <= 1'b0;
            end
            // a change in the clearing cycle wins over the clear
            if (sw_change && mode_q == MODE_NORMAL) begin
                int_q <= 1'b1;
            end else if (cs_rise && !frame_chg_q) begin
                int_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            therm_q <= 1'b0;
        end else begin
            therm_q <= therm_s & (mode_q == MODE_NORMAL);
        end
    end

    // the link reads this word unsynchronised; it is settled well before the
    // first serial clock edge, provided chip select leads by a few clocks
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            snap_q <= '0;
        end else if (cs_fall && vdd_s) begin
            snap_q <= {int_q, therm_q, closed_q};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command decode at chip select rise

    logic       tgl_seen_q;
    logic       fresh;
    logic       len_ok;
    logic       cmd_ok;
    logic [7:0] hdr;
    logic       cal_q;

    assign fresh  = tgl_s ^ tgl_seen_q;
    assign len_ok = (flen_q == CNT_W'(FRAME_BITS)) || (flen_q == CNT_W'(CHAIN_BITS));
    assign cmd_ok = cs_rise & fresh & len_ok & vdd_s & (mode_q == MODE_NORMAL);
    assign hdr    = rx_q[HDR_MSB:HDR_LSB];

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            tgl_seen_q <= 1'b0;
        end else if (cs_rise) begin
            tgl_seen_q <= tgl_s;
        end
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            cfg_q <= CFG_RST;
        end else if (cmd_ok) begin
            unique case (hdr)
                CMD_POLARITY: cfg_q.polarity <= rx_q[NPROG-1:0];
                CMD_WAKE_P:   cfg_q.wake_en  <= merge(cfg_q.wake_en, rx_q, 1'b0);
                CMD_WAKE_G:   cfg_q.wake_en  <= merge(cfg_q.wake_en, rx_q, 1'b1);
                CMD_METAL_P:  cfg_q.metal_hi <= merge(cfg_q.metal_hi, rx_q, 1'b0);
                CMD_METAL_G:  cfg_q.metal_hi <= merge(cfg_q.metal_hi, rx_q, 1'b1);
                CMD_TIMER_P:  cfg_q.timer_en <= merge(cfg_q.timer_en, rx_q, 1'b0);
                CMD_TIMER_G:  cfg_q.timer_en <= merge(cfg_q.timer_en, rx_q, 1'b1);
                CMD_TRI_P:    cfg_q.tristate <= merge(cfg_q.tristate, rx_q, 1'b0);
                CMD_TRI_G:    cfg_q.tristate <= merge(cfg_q.tristate, rx_q, 1'b1);
                CMD_ANALOG: begin
                    cfg_q.ana_sel <= rx_q[ANA_SEL_W-1:0];
                    cfg_q.ana_cur <= rx_q[ANA_CUR_LSB+ANA_CUR_W-1:ANA_CUR_LSB];
                end
                CMD_RESET:    cfg_q <= CFG_RST;
                default: begin
                    // unknown header: keep everything
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            cal_q <= 1'b0;
        end else begin
            cal_q <= cmd_ok & (hdr == CMD_CALIB);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    logic so_oe_q;

    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            so_oe_q <= 1'b0;
        end else begin
            so_oe_q <= vdd_s;
        end
    end

    assign SO_OE_O       = so_oe_q & ~CS_N_I;
    assign INT_N_O       = 1'b0;
    assign INT_N_OE_O    = int_q;
    assign WAKE_N_O      = 1'b0;
    assign WAKE_N_OE_O   = (mode_q == MODE_NORMAL);
    assign STATUS_O      = closed_q;
    assign THERM_FLAG_O  = therm_q;
    assign MODE_NORMAL_O = (mode_q == MODE_NORMAL);
    assign CAL_O         = cal_q;
    assign CFG_O         = cfg_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);

    polarity_map_a: assert property (
        closed_vld_q |-> closed_q[NPROG-1:0] ==
            $past(~(cmp_s[NPROG-1:0] ^ cfg_q.polarity)))
        else $error("programmable input decode wrong");

    ground_map_a: assert property (
        closed_vld_q |-> closed_q[NSW-1:NPROG] == $past(~cmp_s[NSW-1:NPROG]))
        else $error("ground-only input decode wrong");

    snap_capture_a: assert property (
        cs_fall && vdd_s |=> snap_q == {$past(int_q), $past(therm_q), $past(closed_q)})
        else $error("status snapshot not taken at select fall");

    int_release_a: assert property (
        cs_rise && !frame_chg_q && !sw_change |=> !int_q)
        else $error("interrupt not released at select rise");

    int_hold_a: assert property (
        cs_rise && frame_chg_q && int_q |=> int_q)
        else $error("interrupt cleared despite change in frame");

    therm_gate_a: assert property (
        therm_q |-> $past(mode_q == MODE_NORMAL) && $past(therm_s))
        else $error("thermal flag outside Normal mode");

    no_supply_a: assert property (
        !vdd_s || mode_q == MODE_SLEEP |=> $stable(cfg_q))
        else $error("configuration changed without supply or asleep");

    bad_len_a: assert property (
        cs_rise && !len_ok |=> $stable(cfg_q))
        else $error("bad frame length altered configuration");

    pol_load_a: assert property (
        cmd_ok && hdr == CMD_POLARITY |=> cfg_q.polarity == $past(rx_q[NPROG-1:0]))
        else $error("polarity command not loaded");

    cs_wake_a: assert property (
        mode_q == MODE_SLEEP && cs_fall && vdd_s |=> mode_q == MODE_NORMAL)
        else $error("select fall did not wake");

    sleep_hold_a: assert property (
        mode_q == MODE_SLEEP && !wake_evt |=> mode_q == MODE_SLEEP)
        else $error("left Sleep without wake event");

    normal_hold_a: assert property (
        mode_q == MODE_NORMAL && !SLEEP_REQ_I |=> mode_q == MODE_NORMAL)
        else $error("left Normal without sleep request");

endmodule

// ### spi_host_model.sv
`timescale 1ns/10ps
// bench master; its serial clock runs faster than the rated device rate to keep runs short
module spi_host_model
    import swdet_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  start_i,
    input  wire logic [CNT_W-1:0]      nbits_i,
    input  wire logic [CHAIN_BITS-1:0] word_i,
    input  wire logic                  so_i,
    output logic                       sclk_o,
    output logic                       cs_n_o,
    output logic                       si_o,
    output logic                       done_o,
    output logic [CHAIN_BITS-1:0]      rx_o
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        done_o = 1'b0;
        rx_o = '0;
        forever begin
            // data line wanders while deselected so a stale bit never looks valid
            while (start_i !== 1'b1) begin
                @(posedge clk_i);
                si_o = ~si_o;
            end
            rx_o = '0;
            #1 cs_n_o = 1'b0;
            repeat (6) @(posedge clk_i);
            for (int i = int'(nbits_i) - 1; i >= 0; i--) begin
                #1 si_o = word_i[i];
                #23 sclk_o = 1'b1; // period fixed at 48 ns by the bench
                #24 rx_o = {rx_o[CHAIN_BITS-2:0], so_i};
                sclk_o = 1'b0;
            end
            #24 si_o = ~si_o;
            cs_n_o = 1'b1;
            repeat (8) @(posedge clk_i);
            #1 done_o = 1'b1;
            while (start_i !== 1'b0) begin
                @(posedge clk_i);
            end
            #1 done_o = 1'b0;
        end
    end
endmodule

// ### switch_detect_spi_control_tb_top.sv
`timescale 1ns/10ps
module switch_detect_spi_control_tb_top;
    import swdet_pkg::*;

    localparam logic [7:0] HDRS [14] = '{CMD_POLARITY, CMD_WAKE_P, CMD_WAKE_G, CMD_METAL_P,
        CMD_METAL_G, CMD_TIMER_P, CMD_TIMER_G, CMD_TRI_P, CMD_TRI_G, CMD_ANALOG, CMD_CALIB,
        CMD_RESET, 8'h06, 8'h00};
    logic                  clk, rst, vdd_ok, therm, tmr_exp, sleep_req;
    logic                  int_pull, wake_pull, start, done, sclk, cs_n, si, so, so_oe;
    logic                  int_oe, wake_oe, therm_flag, mode_n, cal;
    logic                  idle_pat = 1'b0;
    logic [NPROG-1:0]      pcmp;
    logic [NGND-1:0]       gcmp;
    logic [CNT_W-1:0]      nbits;
    logic [CHAIN_BITS-1:0] word, rx;
    logic [NSW-1:0]        status;
    cfg_t                  cfg;
    logic [31:0]           seed;
    int                    err_total = 0;
    int                    total_checks = 0;
    int                    cal_cnt = 0;

    always @(posedge clk) begin
        idle_pat <= ~idle_pat;
        if (cal === 1'b1) begin
            cal_cnt <= cal_cnt + 1;
        end
    end

    switch_detect_spi_control switch_detect_spi_control_inst (
        .CLOCK_I(clk), .RST_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n), .SI_I(si),
        .SO_O(so), .SO_OE_O(so_oe), .INT_N_I(~(int_oe | int_pull)), .INT_N_O(),
        .INT_N_OE_O(int_oe), .WAKE_N_I(~(wake_oe | wake_pull)), .WAKE_N_O(),
        .WAKE_N_OE_O(wake_oe), .VDD_OK_I(vdd_ok), .THERM_I(therm), .PROG_CMP_I(pcmp),
        .GND_CMP_I(gcmp), .TMR_EXPIRE_I(tmr_exp), .SLEEP_REQ_I(sleep_req),
        .STATUS_O(status), .THERM_FLAG_O(therm_flag), .MODE_NORMAL_O(mode_n),
        .CAL_O(cal), .CFG_O(cfg));

    spi_host_model spi_host_model_inst (
        .clk_i(clk), .start_i(start), .nbits_i(nbits), .word_i(word),
        .so_i(so_oe ? so : idle_pat), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si),
        .done_o(done), .rx_o(rx));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [NSW-1:0] stat(input logic [NPROG-1:0] p,
                                             input logic [NGND-1:0] g,
                                             input logic [NPROG-1:0] pol);
        return {~g, ~(p ^ pol)};
    endfunction

    function automatic cfg_t apply(input cfg_t c, input logic [23:0] w);
        cfg_t r;
        r = c;
        case (w[23:16])
            CMD_POLARITY: r.polarity = w[7:0];
            CMD_WAKE_P:   r.wake_en[NPROG-1:0] = w[7:0];
            CMD_WAKE_G:   r.wake_en[NSW-1:NPROG] = w[NGND-1:0];
            CMD_METAL_P:  r.metal_hi[NPROG-1:0] = w[7:0];
            CMD_METAL_G:  r.metal_hi[NSW-1:NPROG] = w[NGND-1:0];
            CMD_TIMER_P:  r.timer_en[NPROG-1:0] = w[7:0];
            CMD_TIMER_G:  r.timer_en[NSW-1:NPROG] = w[NGND-1:0];
            CMD_TRI_P:    r.tristate[NPROG-1:0] = w[7:0];
            CMD_TRI_G:    r.tristate[NSW-1:NPROG] = w[NGND-1:0];
            CMD_ANALOG: begin
                r.ana_sel = w[4:0];
                r.ana_cur = w[6:5];
            end
            CMD_RESET:    r = CFG_RST;
            default:      r = c;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic frame(input logic [CNT_W-1:0] n, input logic [CHAIN_BITS-1:0] w);
        int k;
        nbits <= n;
        word <= w;
        start <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (done !== 1'b1 && k < 3000);
        if (k >= 3000) begin
            err_total++;
            tally_and_finish();
        end
        start <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic pulse_sleep();
        sleep_req <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [NSW-1:0]        expst, prev;
        logic [CHAIN_BITS-1:0] w;
        logic [7:0]            hd;
        logic                  iexp;
        cfg_t                  ec;
        int                    cal0, n;
        rst = 1'b1;
        vdd_ok = 1'b1;
        therm = 1'b0;
        tmr_exp = 1'b0;
        sleep_req = 1'b0;
        int_pull = 1'b0;
        wake_pull = 1'b0;
        pcmp = '0;
        gcmp = '1;
        start = 1'b0;
        nbits = '0;
        word = '0;
        seed = 32'h0A71;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        ec = CFG_RST;
        check("cfg", 128'(cfg), 128'(ec));
        check("mode", 128'(mode_n), 128'(1));
        for (int i = 0; i < 22; i++) begin
            seed = lfsr_next(seed);
            hd = HDRS[(i < 14) ? i : int'(seed[3:0]) % 14];
            w = {seed[31:8], hd, seed[15:0]};
            n = (i % 5 == 4) ? 48 : 24;
            cal0 = cal_cnt;
            frame(CNT_W'(n), w);
            ec = apply(ec, w[23:0]);
            check("cfg", 128'(cfg), 128'(ec));
            check("cal", 128'(cal_cnt - cal0), 128'(hd == CMD_CALIB));
            if (n == 48) begin
                check("echo", 128'(rx[23:0]), 128'(w[47:24]));
            end
            frame(24, 48'h0);
            prev = stat(pcmp, gcmp, ec.polarity);
            seed = lfsr_next(seed);
            pcmp <= seed[7:0];
            gcmp <= seed[21:8];
            therm <= seed[24];
            repeat (8) @(posedge clk);
            expst = stat(pcmp, gcmp, ec.polarity);
            iexp = |((expst ^ prev) & ec.wake_en);
            check("status", 128'(status), 128'(expst));
            check("int", 128'(int_oe), 128'(iexp));
            check("therm", 128'(therm_flag), 128'(therm));
            frame(24, {32'h0, seed[15:0]});
            check("so_sw", 128'(rx[21:0]), 128'(expst));
            check("so_flags", 128'(rx[23:22]), 128'({iexp, therm}));
            check("int_clr", 128'(int_oe), 128'(0));
            check("cfg_keep", 128'(cfg), 128'(ec));
        end
        for (int i = 0; i < 4; i++) begin
            n = (i == 0) ? 0 : 21 + 2 * i;
            frame(CNT_W'(n), {24'h0, CMD_POLARITY, 8'h00, ~ec.polarity});
            check("cfg_len", 128'(cfg), 128'(ec));
        end
        frame(24, {24'h0, CMD_RESET, 16'h0});
        ec = CFG_RST;
        frame(24, 48'h0);
        fork
            frame(24, 48'h0);
            begin
                repeat (40) @(posedge clk);
                gcmp <= ~gcmp;
            end
        join
        check("int_hold", 128'(int_oe), 128'(1));
        frame(24, 48'h0);
        check("int_clr", 128'(int_oe), 128'(0));
        therm <= 1'b0;
        for (int e = 0; e < 5; e++) begin
            pulse_sleep();
            check("sleep", 128'({mode_n, wake_oe}), 128'(0));
            case (e)
                0: wake_pull <= 1'b1;
                1: int_pull <= 1'b1;
                2: tmr_exp <= 1'b1;
                3: frame(24, {24'h0, CMD_POLARITY, 16'h005A});
                default: pcmp <= ~pcmp;
            endcase
            @(posedge clk);
            wake_pull <= 1'b0;
            int_pull <= 1'b0;
            tmr_exp <= 1'b0;
            repeat (6) @(posedge clk);
            check("wake", 128'(mode_n), 128'(1));
        end
        ec.polarity = 8'h5A;
        check("cfg_wake", 128'(cfg), 128'(ec));
        vdd_ok <= 1'b0;
        repeat (6) @(posedge clk);
        check("mode_novdd", 128'(mode_n), 128'(1));
        frame(24, {24'h0, CMD_POLARITY, 16'h00C3});
        check("cfg_novdd", 128'(cfg), 128'(ec));
        pulse_sleep();
        frame(24, 48'h0);
        int_pull <= 1'b1;
        therm <= 1'b1;
        repeat (8) @(posedge clk);
        int_pull <= 1'b0;
        check("asleep", 128'({mode_n, therm_flag}), 128'(0));
        wake_pull <= 1'b1;
        repeat (2) @(posedge clk);
        wake_pull <= 1'b0;
        repeat (8) @(posedge clk);
        check("wake_novdd", 128'({mode_n, therm_flag}), 128'(3));
        vdd_ok <= 1'b1;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        check("cfg_por", 128'(cfg), 128'(CFG_RST));
        check("mode_por", 128'(mode_n), 128'(1));
        tally_and_finish();
    end
endmodule
